/* rtl/tws_regs.svh */
/*
 * Register offsets, field positions, reset values and widths of the
 * two-wire slave. Assumes a 12-bit byte address on the register port.
 */
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH

`define TWS_AW          12
`define TWS_CNT_W       16
`define TWS_OFF_STOP    12'h014
`define TWS_OFF_SUSP    12'h01c
`define TWS_OFF_RESUME  12'h020
`define TWS_OFF_ARMRX   12'h030
`define TWS_OFF_ARMTX   12'h034
`define TWS_OFF_EVHALT  12'h104
`define TWS_OFF_EVFAULT 12'h124
`define TWS_OFF_EVRXB   12'h14c
`define TWS_OFF_EVTXB   12'h150
`define TWS_OFF_EVWR    12'h164
`define TWS_OFF_EVRD    12'h168
`define TWS_OFF_LINKS   12'h200
`define TWS_OFF_IEN     12'h300
`define TWS_OFF_IENSET  12'h304
`define TWS_OFF_IENCLR  12'h308
`define TWS_OFF_PEND    12'h30c
`define TWS_OFF_FCAUSE  12'h4d0
`define TWS_OFF_MATCH   12'h4d4
`define TWS_OFF_ON      12'h500
`define TWS_OFF_PSCL    12'h508
`define TWS_OFF_PSDA    12'h50c
`define TWS_OFF_RXPTR   12'h534
`define TWS_OFF_RXMAX   12'h538
`define TWS_OFF_RXAMT   12'h53c
`define TWS_OFF_RXLIST  12'h540
`define TWS_OFF_TXPTR   12'h544
`define TWS_OFF_TXMAX   12'h548
`define TWS_OFF_TXAMT   12'h54c
`define TWS_OFF_TXLIST  12'h550
`define TWS_OFF_ADDR0   12'h588
`define TWS_OFF_ADDR1   12'h58c
`define TWS_OFF_CFG     12'h594
`define TWS_OFF_ORC     12'h5c0
// Event bit positions in event, enable and pending vectors
`define TWS_EV_HALT     3'h0
`define TWS_EV_FAULT    3'h1
`define TWS_EV_RXB      3'h2
`define TWS_EV_TXB      3'h3
`define TWS_EV_WR       3'h4
`define TWS_EV_RD       3'h5
// Link bits: command events straight to suspend
`define TWS_LK_WR_SUSP  0
`define TWS_LK_RD_SUSP  1
// Fault cause bits
`define TWS_FC_OVERFLOW 0
`define TWS_FC_OVERREAD 1
`define TWS_ON_VALUE    4'h1
`define TWS_PSEL_OFF    6'h20

`endif

/* rtl/tws_pkg.sv */
/*
 * Types of the two-wire slave: bus and memory carriers, engine states
 * and the module state record. Assumes tws_regs.svh on the include path.
 */
`include "tws_regs.svh"

package tws_pkg;

	typedef struct packed {
		logic [`TWS_AW-1:0] addr;
		logic [31:0]        wdata;
		logic               wr;
		logic               rd;
	} tws_bus_req_type;

	typedef struct packed {
		logic [31:0] addr;
		logic [7:0]  wdata;
		logic        we;
		logic        re;
	} tws_mem_req_type;

	typedef enum logic [3:0] {
		ST_IDLE     = 4'b0000,
		ST_ADDR     = 4'b0001,
		ST_ADDR_END = 4'b0010,
		ST_ACK_ADDR = 4'b0011,
		ST_GATE     = 4'b0100,
		ST_RX       = 4'b0101,
		ST_RX_END   = 4'b0110,
		ST_ACK_RX   = 4'b0111,
		ST_TX_FETCH = 4'b1000,
		ST_TX_LOAD  = 4'b1001,
		ST_TX       = 4'b1010,
		ST_TX_ACK   = 4'b1011,
		ST_DONE     = 4'b1100
	} tws_fsm_type;

	typedef struct packed {
		logic                  en;
		logic [5:0]            c_psel, d_psel;
		logic [5:0]            ev, pend, irq_enable;
		logic [1:0]            links, fcause, cfg, rxlist, txlist;
		logic                  match;
		logic [6:0]            addr0, addr1;
		logic [7:0]            overread_fill_byte, sh;
		logic [31:0]           rxptr, txptr, lptr, rdata;
		logic [`TWS_CNT_W-1:0] rxmax, txmax, rxamt, txamt, lmax, cnt;
		logic                  scl_s1, scl_s2, scl_s3;
		logic                  sda_s1, sda_s2, sda_s3;
		tws_fsm_type           fsm;
		logic [2:0]            bitcnt;
		logic                  rw, nack, xfer, rxprep, txprep, susp;
		logic                  sda_drv;
		tws_mem_req_type       mem;
	} tws_state_type;

endpackage : tws_pkg

/* rtl/tws_slave.sv */
/*
 * Two-wire slave: register port, pin routing over the GPIO pads, bus
 * engine with clock stretching and a byte-wide buffer memory port.
 * Assumes a memory that answers a read one cycle after mem_req.re and
 * a system power state input that is high in ON mode.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tws_regs.svh"

module tws_slave #(
	parameter int NPINS = 32
) (
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	input  wire tws_pkg::tws_bus_req_type bus_req,
	output logic [31:0]                   bus_rdata,
	input  wire logic                     sys_on,
	input  wire logic [NPINS-1:0]         pin_in,
	input  wire logic [NPINS-1:0]         gpio_out,
	input  wire logic [NPINS-1:0]         gpio_oe,
	output logic [NPINS-1:0]              pad_out,
	output logic [NPINS-1:0]              pad_oe,
	output tws_pkg::tws_mem_req_type      mem_req,
	input  wire logic [7:0]               mem_rdata,
	output logic                          irq
);
	import tws_pkg::*;

	tws_state_type q;
	tws_state_type n;
	logic          wr;
	logic          rd;
	logic [31:0]   wd;
	logic          t_stop;
	logic          ev_hit;
	logic [2:0]    ev_idx;
	logic [5:0]    evs;
	logic [1:0]    fc_set;
	logic          scl_raw;
	logic          sda_raw;
	logic          scl_r;
	logic          scl_f;
	logic          start;
	logic          stop;
	logic          in_rng;
	logic          ready;
	logic          fin;
	logic          m0;
	logic          m1;
	logic          scl_drv;

	// ------------------------------------------------------------
	// Pad routing
	// ------------------------------------------------------------
	// Holding the clock low covers waiting for software, a pending
	// suspend and the memory fetch of the next transmit byte.
	// clock stretch
	assign scl_drv = q.en && ((q.fsm == ST_GATE && !ready) ||
		q.fsm == ST_TX_FETCH || q.fsm == ST_TX_LOAD ||
		(q.susp && !q.scl_s2 && q.fsm != ST_IDLE && q.fsm != ST_DONE));

	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			pad_out[i] = gpio_out[i];
			pad_oe[i]  = gpio_oe[i];
			if (q.en && !q.c_psel[5] && q.c_psel[4:0] == 5'(i)) begin
				pad_out[i] = 1'b0;
				pad_oe[i]  = scl_drv;
			end
			if (q.en && !q.d_psel[5] && q.d_psel[4:0] == 5'(i)) begin
				pad_out[i] = 1'b0;
				pad_oe[i]  = q.sda_drv;
			end
		end
	end

	// Unselected lines read as idle-high so no false start appears
	assign scl_raw = q.c_psel[5] ? 1'b1 : pin_in[q.c_psel[4:0]];
	assign sda_raw = q.d_psel[5] ? 1'b1 : pin_in[q.d_psel[4:0]];

	assign bus_rdata = q.rdata;
	assign mem_req   = q.mem;
	assign irq       = |(q.pend & q.irq_enable);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		n          = q;
		evs        = '0;
		fc_set     = '0;
		t_stop     = 1'b0;
		fin        = 1'b0;
		ev_hit     = 1'b0;
		ev_idx     = 3'h0;
		n.mem.we   = 1'b0;
		n.mem.re   = 1'b0;
		n.rdata    = '0;
		wr         = bus_req.wr;
		rd         = bus_req.rd;
		wd         = bus_req.wdata;
		n.scl_s1   = scl_raw;
		n.scl_s2   = q.scl_s1;
		n.scl_s3   = q.scl_s2;
		n.sda_s1   = sda_raw;
		n.sda_s2   = q.sda_s1;
		n.sda_s3   = q.sda_s2;
		scl_r      = q.scl_s2 && !q.scl_s3;
		scl_f      = !q.scl_s2 && q.scl_s3;
		start      = q.scl_s2 && q.scl_s3 && q.sda_s3 && !q.sda_s2;
		stop       = q.scl_s2 && q.scl_s3 && !q.sda_s3 && q.sda_s2;
		in_rng     = q.cnt < q.lmax;
		ready      = (q.rw ? q.txprep : q.rxprep) && !q.susp;
		m0         = q.cfg[0] && q.sh[6:0] == q.addr0;
		m1         = q.cfg[1] && q.sh[6:0] == q.addr1;

		case (bus_req.addr)
			`TWS_OFF_EVHALT:  begin ev_hit = 1'b1; ev_idx = `TWS_EV_HALT; end
			`TWS_OFF_EVFAULT: begin ev_hit = 1'b1; ev_idx = `TWS_EV_FAULT; end
			`TWS_OFF_EVRXB:   begin ev_hit = 1'b1; ev_idx = `TWS_EV_RXB; end
			`TWS_OFF_EVTXB:   begin ev_hit = 1'b1; ev_idx = `TWS_EV_TXB; end
			`TWS_OFF_EVWR:    begin ev_hit = 1'b1; ev_idx = `TWS_EV_WR; end
			`TWS_OFF_EVRD:    begin ev_hit = 1'b1; ev_idx = `TWS_EV_RD; end
			default:          begin ev_hit = 1'b0; ev_idx = 3'h0; end
		endcase

		// --------------------------------------------------------
		// Register writes
		// --------------------------------------------------------
		if (wr) begin
			if (ev_hit)
				n.ev[ev_idx] = wd[0];
			case (bus_req.addr)
				// tasks act on a one only
				`TWS_OFF_STOP:   t_stop = wd[0];
				`TWS_OFF_SUSP:   if (wd[0]) n.susp = 1'b1;
				`TWS_OFF_RESUME: if (wd[0]) n.susp = 1'b0;
				`TWS_OFF_ARMRX:  if (wd[0]) n.rxprep = 1'b1;
				`TWS_OFF_ARMTX:  if (wd[0]) n.txprep = 1'b1;
				`TWS_OFF_LINKS:  n.links = wd[1:0];
				`TWS_OFF_IEN:    n.irq_enable = wd[5:0];
				`TWS_OFF_IENSET: n.irq_enable = q.irq_enable | wd[5:0];
				`TWS_OFF_IENCLR: n.irq_enable = q.irq_enable & ~wd[5:0];
				`TWS_OFF_FCAUSE: n.fcause = q.fcause & ~wd[1:0];
				`TWS_OFF_ON:     n.en = wd[3:0] == `TWS_ON_VALUE;
				`TWS_OFF_PSCL:   if (!q.en) n.c_psel = {wd[31], wd[4:0]};
				`TWS_OFF_PSDA:   if (!q.en) n.d_psel = {wd[31], wd[4:0]};
				`TWS_OFF_RXPTR:  n.rxptr = wd;
				`TWS_OFF_RXMAX:  n.rxmax = wd[`TWS_CNT_W-1:0];
				`TWS_OFF_RXLIST: n.rxlist = wd[1:0];
				`TWS_OFF_TXPTR:  n.txptr = wd;
				`TWS_OFF_TXMAX:  n.txmax = wd[`TWS_CNT_W-1:0];
				`TWS_OFF_TXLIST: n.txlist = wd[1:0];
				`TWS_OFF_ADDR0:  n.addr0 = wd[6:0];
				`TWS_OFF_ADDR1:  n.addr1 = wd[6:0];
				`TWS_OFF_CFG:    n.cfg = wd[1:0];
				`TWS_OFF_ORC:    n.overread_fill_byte = wd[7:0];
				default:         n.en = q.en;
			endcase
		end

		// --------------------------------------------------------
		// Register reads
		// --------------------------------------------------------
		if (rd) begin
			if (ev_hit)
				n.rdata = {31'h0, q.ev[ev_idx]};
			case (bus_req.addr)
				`TWS_OFF_LINKS:  n.rdata = {30'h0, q.links};
				`TWS_OFF_IEN,
				`TWS_OFF_IENSET,
				`TWS_OFF_IENCLR: n.rdata = {26'h0, q.irq_enable};
				`TWS_OFF_PEND:   n.rdata = {26'h0, q.pend};
				`TWS_OFF_FCAUSE: n.rdata = {30'h0, q.fcause};
				`TWS_OFF_MATCH:  n.rdata = {31'h0, q.match};
				`TWS_OFF_ON:     n.rdata = {28'h0, q.en ? `TWS_ON_VALUE : 4'h0};
				`TWS_OFF_PSCL:   n.rdata = {q.c_psel[5], 26'h0, q.c_psel[4:0]};
				`TWS_OFF_PSDA:   n.rdata = {q.d_psel[5], 26'h0, q.d_psel[4:0]};
				`TWS_OFF_RXPTR:  n.rdata = q.rxptr;
				`TWS_OFF_RXMAX:  n.rdata = 32'(q.rxmax);
				`TWS_OFF_RXAMT:  n.rdata = 32'(q.rxamt);
				`TWS_OFF_RXLIST: n.rdata = {30'h0, q.rxlist};
				`TWS_OFF_TXPTR:  n.rdata = q.txptr;
				`TWS_OFF_TXMAX:  n.rdata = 32'(q.txmax);
				`TWS_OFF_TXAMT:  n.rdata = 32'(q.txamt);
				`TWS_OFF_TXLIST: n.rdata = {30'h0, q.txlist};
				`TWS_OFF_ADDR0:  n.rdata = {25'h0, q.addr0};
				`TWS_OFF_ADDR1:  n.rdata = {25'h0, q.addr1};
				`TWS_OFF_CFG:    n.rdata = {30'h0, q.cfg};
				`TWS_OFF_ORC:    n.rdata = {24'h0, q.overread_fill_byte};
				default:         n.rdata = n.rdata;
			endcase
		end

		// --------------------------------------------------------
		// Bus engine
		// --------------------------------------------------------
		if (t_stop) begin
			// halt whether or not the bus saw a stop
			evs[`TWS_EV_HALT] = 1'b1;
			fin      = 1'b1;
			n.rxprep = 1'b0;
			n.txprep = 1'b0;
			n.fsm    = ST_IDLE;
		end else if (!q.en) begin
			n.fsm     = ST_IDLE;
			n.sda_drv = 1'b0;
			n.xfer    = 1'b0;
		end else if (stop && q.fsm != ST_IDLE) begin
			evs[`TWS_EV_HALT] = 1'b1;
			fin      = 1'b1;
			n.rxprep = 1'b0;
			n.txprep = 1'b0;
			n.fsm    = ST_IDLE;
		end else if (start) begin
			// A repeated start ends the transfer but keeps preparation
			fin      = 1'b1;
			n.fsm    = ST_ADDR;
			n.bitcnt = 3'h0;
		end else begin
			case (q.fsm)
				ST_ADDR: if (scl_r) begin
					n.sh     = {q.sh[6:0], q.sda_s2};
					n.bitcnt = q.bitcnt + 3'h1;
					if (q.bitcnt == 3'h7) begin
						n.rw  = q.sda_s2;
						n.fsm = (m0 || m1) ? ST_ADDR_END : ST_DONE;
						if (m0 || m1)
							n.match = !m0;
					end
				end
				ST_ADDR_END: if (scl_f) begin
					n.sda_drv = 1'b1;
					n.fsm     = ST_ACK_ADDR;
					evs[`TWS_EV_WR] = !q.rw;
					evs[`TWS_EV_RD] = q.rw;
					if (q.rw ? q.links[`TWS_LK_RD_SUSP] : q.links[`TWS_LK_WR_SUSP])
						n.susp = 1'b1;
				end
				ST_ACK_ADDR: if (scl_f) begin
					n.sda_drv = 1'b0;
					n.fsm     = ST_GATE;
				end
				ST_GATE: if (ready) begin
					// pointer and limit taken once armed, after the address ack
					n.lptr   = q.rw ? q.txptr : q.rxptr;
					n.lmax   = q.rw ? q.txmax : q.rxmax;
					n.cnt    = '0;
					n.xfer   = 1'b1;
					n.bitcnt = 3'h0;
					if (q.rw) begin
						n.txprep = 1'b0;
						evs[`TWS_EV_TXB] = 1'b1;
						n.fsm    = ST_TX_FETCH;
					end else begin
						n.rxprep = 1'b0;
						evs[`TWS_EV_RXB] = 1'b1;
						n.fsm    = ST_RX;
					end
				end
				ST_RX: if (scl_r) begin
					n.sh     = {q.sh[6:0], q.sda_s2};
					n.bitcnt = q.bitcnt + 3'h1;
					if (q.bitcnt == 3'h7)
						n.fsm = ST_RX_END;
				end
				ST_RX_END: if (scl_f) begin
					n.fsm = ST_ACK_RX;
					if (in_rng) begin
						n.mem.we    = 1'b1;
						n.mem.addr  = q.lptr + 32'(q.cnt);
						n.mem.wdata = q.sh;
						n.cnt       = q.cnt + 1'b1;
						n.sda_drv   = 1'b1;
					end else begin
						fc_set[`TWS_FC_OVERFLOW] = 1'b1;
						evs[`TWS_EV_FAULT]       = 1'b1;
					end
				end
				ST_ACK_RX: if (scl_f) begin
					n.sda_drv = 1'b0;
					n.fsm     = ST_RX;
				end
				ST_TX_FETCH: begin
					n.mem.re   = in_rng;
					n.mem.addr = q.lptr + 32'(q.cnt);
					n.fsm      = ST_TX_LOAD;
				end
				// First pass waits for the memory answer to a fetch
				ST_TX_LOAD: if (!q.mem.re) begin
					n.bitcnt = 3'h0;
					n.fsm    = ST_TX;
					if (in_rng) begin
						n.sh  = mem_rdata;
						n.cnt = q.cnt + 1'b1;
					end else begin
						n.sh = q.overread_fill_byte;
						fc_set[`TWS_FC_OVERREAD] = 1'b1;
						evs[`TWS_EV_FAULT]       = 1'b1;
					end
					n.sda_drv = !n.sh[7];
				end
				ST_TX: if (scl_f) begin
					if (q.bitcnt == 3'h7) begin
						n.sda_drv = 1'b0;
						n.fsm     = ST_TX_ACK;
					end else begin
						n.bitcnt  = q.bitcnt + 3'h1;
						n.sh      = {q.sh[6:0], 1'b0};
						n.sda_drv = !q.sh[6];
					end
				end
				ST_TX_ACK: begin
					if (scl_r)
						n.nack = q.sda_s2;
					if (scl_f)
						n.fsm = q.nack ? ST_DONE : ST_TX_FETCH;
				end
				ST_IDLE, ST_DONE: n.fsm = q.fsm;
				default: n.fsm = ST_IDLE;
			endcase
		end

		// byte counts of the last transfer
		if (fin) begin
			if (q.xfer && q.rw)
				n.txamt = q.cnt;
			if (q.xfer && !q.rw)
				n.rxamt = q.cnt;
			n.xfer    = 1'b0;
			n.sda_drv = 1'b0;
		end

		// selects are lost outside ON mode
		if (!sys_on) begin
			n.c_psel = `TWS_PSEL_OFF;
			n.d_psel = `TWS_PSEL_OFF;
		end

		// Hardware sets win over software clears
		n.ev     = n.ev | evs;
		n.pend   = ((rd && bus_req.addr == `TWS_OFF_PEND) ? 6'h0 : q.pend) | evs;
		n.fcause = n.fcause | fc_set;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			q        <= '0;
			q.c_psel <= `TWS_PSEL_OFF;
			q.d_psel <= `TWS_PSEL_OFF;
			q.scl_s1 <= 1'b1;
			q.scl_s2 <= 1'b1;
			q.scl_s3 <= 1'b1;
			q.sda_s1 <= 1'b1;
			q.sda_s2 <= 1'b1;
			q.sda_s3 <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	property p_halt_on_stop;
		bus_req.wr && bus_req.addr == `TWS_OFF_STOP && bus_req.wdata[0]
			|=> q.ev[`TWS_EV_HALT] && q.fsm == ST_IDLE && !q.sda_drv;
	endproperty
	a_halt_on_stop: assert property (p_halt_on_stop)
		else $error("stop task did not halt");

	property p_ien_set;
		bus_req.wr && bus_req.addr == `TWS_OFF_IENSET
			|=> q.irq_enable == ($past(q.irq_enable) | $past(bus_req.wdata[5:0]));
	endproperty
	a_ien_set: assert property (p_ien_set)
		else $error("enable set alias wrong");

	property p_ien_clr;
		bus_req.wr && bus_req.addr == `TWS_OFF_IENCLR
			|=> q.irq_enable == ($past(q.irq_enable) & ~$past(bus_req.wdata[5:0]));
	endproperty
	a_ien_clr: assert property (p_ien_clr)
		else $error("enable clear alias wrong");

	property p_gpio_back;
		!q.en |-> pad_oe == gpio_oe && pad_out == gpio_out;
	endproperty
	a_gpio_back: assert property (p_gpio_back)
		else $error("disabled slave still drives a pad");

	property p_stretch;
		q.en && q.susp && !q.scl_s2 && !q.c_psel[5]
			&& (q.fsm == ST_ACK_ADDR || q.fsm == ST_GATE)
			|-> pad_oe[q.c_psel[4:0]] && !pad_out[q.c_psel[4:0]];
	endproperty
	a_stretch: assert property (p_stretch)
		else $error("clock not held while suspended");

	property p_rx_limit;
		q.en && q.fsm == ST_RX_END && scl_f && !in_rng && !start && !stop
			&& !t_stop |=> !q.mem.we && q.fcause[`TWS_FC_OVERFLOW];
	endproperty
	a_rx_limit: assert property (p_rx_limit)
		else $error("byte stored past receive limit");

	property p_fill;
		q.en && q.fsm == ST_TX_LOAD && !in_rng && !t_stop && !start && !stop
			|=> q.sh == $past(q.overread_fill_byte) && q.ev[`TWS_EV_FAULT];
	endproperty
	a_fill: assert property (p_fill)
		else $error("over-read did not send fill byte");

	property p_rx_amount;
		fin && q.xfer && !q.rw |=> q.rxamt == $past(q.cnt);
	endproperty
	a_rx_amount: assert property (p_rx_amount)
		else $error("receive count not stored");

	property p_off_mode;
		!sys_on |=> q.c_psel == `TWS_PSEL_OFF && q.d_psel == `TWS_PSEL_OFF;
	endproperty
	a_off_mode: assert property (p_off_mode)
		else $error("pin select kept outside ON mode");

endmodule : tws_slave

`default_nettype wire

/* test/tws_master_model.sv */
/*
 * Behavioural two-wire bus master for the slave bench.
 * Assumes open-drain lines with pull-ups built by the bench from the pulls.
 */
`timescale 1ns/1ps
`default_nettype none

module tws_master_model (
	input  wire logic scl,
	input  wire logic sda,
	output var logic  scl_pull,
	output var logic  sda_pull
);
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end

	// --------------------------------------------------
	// Bit and frame primitives, 125 ns per bit
	// --------------------------------------------------
	// Bounded wait on a stretched clock so a stuck slave cannot hang us
	task automatic bit_io(input logic b, output logic s);
		int n;
		n = 0;
		sda_pull = ~b;
		#31;
		scl_pull = 1'b0;
		while (!scl && n < 5000) begin
			#10;
			n++;
		end
		#31;
		s = sda;
		#31;
		scl_pull = 1'b1;
		#32;
	endtask : bit_io

	task automatic start();
		sda_pull = 1'b1;
		#62;
		scl_pull = 1'b1;
		#31;
	endtask : start

	task automatic stop();
		sda_pull = 1'b1;
		#31;
		scl_pull = 1'b0;
		#31;
		sda_pull = 1'b0;
		#62;
	endtask : stop

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask : wbyte

	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 0; i < 8; i++) begin
			bit_io(1'b1, s);
			d = {d[6:0], s};
		end
		bit_io(nack, s);
	endtask : rbyte
endmodule : tws_master_model

`default_nettype wire

/* test/tws_slave_test.sv */
/*
 * Self-checking bench of the two-wire slave: register tasks, byte memory
 * model, open-drain pads. Assumes the master model and tws_regs.svh.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tws_regs.svh"

module tws_slave_test;
	import tws_pkg::*;
	logic            core_clk, rst, sys_on, irq, scl_pull, sda_pull, ack;
	tws_bus_req_type bus_req;
	tws_mem_req_type mem_req;
	logic [31:0]     bus_rdata, gpio_out, gpio_oe, pad_out, pad_oe, pin_in, v;
	logic [7:0]      mem_rdata, b;
	int              error_cnt, samples_checked, seed, cyc;
	logic [39:0]     got_q[$], exp_q[$];

	tws_slave u_dut (.core_clk(core_clk), .rst(rst), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .sys_on(sys_on), .pin_in(pin_in),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .pad_out(pad_out),
		.pad_oe(pad_oe), .mem_req(mem_req), .mem_rdata(mem_rdata), .irq(irq));
	tws_master_model u_mst (.scl(pin_in[3]), .sda(pin_in[5]),
		.scl_pull(scl_pull), .sda_pull(sda_pull));

	// Wired-and lines: clock on pad 3, data on pad 5
	assign pin_in = (~pad_oe | pad_out)
		& ~{26'h0, sda_pull, 1'b0, scl_pull, 3'h0};

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// --------------------------------------------------
	// Buffer memory model and timeout
	// --------------------------------------------------
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (mem_req.re) mem_rdata <= mem_req.addr[7:0] ^ 8'h5a;
		if (mem_req.we) got_q.push_back({mem_req.addr, mem_req.wdata});
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end

	// --------------------------------------------------
	// Tasks
	// --------------------------------------------------
	task automatic chk(input string n, input logic [31:0] g, e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
	endtask : wr

	task automatic rchk(input string n, input logic [11:0] a,
		input logic [31:0] e);
		@(posedge core_clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		#1 chk(n, bus_rdata, e);
	endtask : rchk

	task automatic mw(input logic [7:0] d, input logic e);
		u_mst.wbyte(d, ack);
		chk("ack", {31'h0, ack}, {31'h0, e});
	endtask : mw

	task automatic results();
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results

	initial begin
		seed = 43;
		rst = 1'b1;
		sys_on = 1'b1;
		bus_req = '0;
		gpio_out = '0;
		gpio_oe = '0;
		mem_rdata = '0;
		cyc = 0;
		error_cnt = 0;
		samples_checked = 0;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		rchk("pscl", `TWS_OFF_PSCL, 32'h8000_0000);
		rchk("stop_rd", `TWS_OFF_STOP, 32'h0);
		wr(`TWS_OFF_STOP, 32'h2);
		rchk("halt0", `TWS_OFF_EVHALT, 32'h0);
		wr(`TWS_OFF_STOP, 32'h1);
		rchk("halt1", `TWS_OFF_EVHALT, 32'h1);
		wr(`TWS_OFF_EVHALT, 32'h0);
		rchk("halt_clr", `TWS_OFF_EVHALT, 32'h0);
		rchk("unmapped", 12'h7fc, 32'h0);
		$display("test registers done");
		// Pads 3 and 5 kept released so the lines idle high
		// bus pads input only
		repeat (8) begin
			@(posedge core_clk);
			gpio_out <= $random(seed);
			gpio_oe <= $random(seed) & 32'hffff_ffd7;
			@(negedge core_clk);
			chk("pad_out", pad_out, gpio_out);
			chk("pad_oe", pad_oe, gpio_oe);
		end
		$display("test disabled pads done");
		// Pin selects are written before enabling
		wr(`TWS_OFF_PSCL, 32'h3);
		wr(`TWS_OFF_PSDA, 32'h5);
		wr(`TWS_OFF_ADDR0, 32'h2a);
		wr(`TWS_OFF_ADDR1, 32'h31);
		wr(`TWS_OFF_CFG, 32'h3);
		wr(`TWS_OFF_ON, 32'h1);
		wr(`TWS_OFF_PSCL, 32'h7);
		rchk("psel_locked", `TWS_OFF_PSCL, 32'h3);
		wr(`TWS_OFF_RXPTR, 32'h40);
		wr(`TWS_OFF_RXMAX, 32'h2);
		wr(`TWS_OFF_ARMRX, 32'h1);
		wr(`TWS_OFF_IENSET, 32'h10);
		wr(`TWS_OFF_IENSET, 32'h01);
		rchk("ien", `TWS_OFF_IEN, 32'h11);
		u_mst.start();
		mw(8'h54, 1'b1);
		mw(8'hc3, 1'b1);
		mw(8'h3c, 1'b1);
		u_mst.stop();
		exp_q.push_back({32'h40, 8'hc3});
		exp_q.push_back({32'h41, 8'h3c});
		repeat (10) @(posedge core_clk);
		chk("irq", {31'h0, irq}, 32'h1);
		rchk("rxamt", `TWS_OFF_RXAMT, 32'h2);
		rchk("match0", `TWS_OFF_MATCH, 32'h0);
		rchk("halted", `TWS_OFF_EVHALT, 32'h1);
		rchk("wr_ev", `TWS_OFF_EVWR, 32'h1);
		rchk("pend", `TWS_OFF_PEND, 32'h15);
		@(negedge core_clk);
		chk("irq_clr", {31'h0, irq}, 32'h0);
		wr(`TWS_OFF_IENCLR, 32'h10);
		rchk("ien_clr", `TWS_OFF_IEN, 32'h01);
		$display("test write command done");
		wr(`TWS_OFF_RXMAX, 32'h1);
		wr(`TWS_OFF_ARMRX, 32'h1);
		u_mst.start();
		mw(8'h54, 1'b1);
		mw(8'h11, 1'b1);
		mw(8'h22, 1'b0);
		u_mst.stop();
		exp_q.push_back({32'h40, 8'h11});
		rchk("rx_fault", `TWS_OFF_EVFAULT, 32'h1);
		rchk("rx_cause", `TWS_OFF_FCAUSE, 32'h1);
		rchk("rxamt1", `TWS_OFF_RXAMT, 32'h1);
		chk("wr_cnt", got_q.size(), exp_q.size());
		foreach (exp_q[i]) begin
			chk("mem_addr", got_q[i][39:8], exp_q[i][39:8]);
			chk("mem_data", {24'h0, got_q[i][7:0]}, {24'h0, exp_q[i][7:0]});
		end
		$display("test receive limit done");
		wr(`TWS_OFF_TXPTR, 32'h80);
		wr(`TWS_OFF_TXMAX, 32'h1);
		wr(`TWS_OFF_ORC, 32'he7);
		wr(`TWS_OFF_LINKS, 32'h2);
		wr(`TWS_OFF_ARMTX, 32'h1);
		u_mst.start();
		// The read event suspends at once, so the address ack is held
		fork
			begin
				mw(8'h63, 1'b1);
				u_mst.rbyte(1'b0, b);
			end
			begin
				repeat (200) @(posedge core_clk);
				chk("stretch", {31'h0, pin_in[3]}, 32'h0);
				wr(`TWS_OFF_RESUME, 32'h1);
			end
		join
		chk("tx_byte", {24'h0, b}, 32'hda);
		u_mst.rbyte(1'b1, b);
		chk("fill", {24'h0, b}, 32'he7);
		u_mst.stop();
		rchk("txamt", `TWS_OFF_TXAMT, 32'h1);
		rchk("match1", `TWS_OFF_MATCH, 32'h1);
		rchk("tx_cause", `TWS_OFF_FCAUSE, 32'h3);
		$display("test read command done");
		@(posedge core_clk);
		sys_on <= 1'b0;
		rchk("psel_off", `TWS_OFF_PSDA, 32'h8000_0000);
		$display("test power state done");
		results();
	end
endmodule : tws_slave_test

`default_nettype wire
